// >>> hdl/rspmp_pkg.sv
package rspmp_pkg;

	// Map of the configuration port
	localparam logic [5:0] ADDR_PIN2_CFG       = 6'h00;
	localparam logic [5:0] ADDR_PIN1_CFG       = 6'h01;
	localparam logic [5:0] ADDR_PIN0_CFG       = 6'h02;
	localparam logic [5:0] ADDR_FILL_THRESHOLD = 6'h03;
	localparam logic [5:0] ADDR_CONFIG_LAST    = 6'h2F;
	localparam logic [5:0] ADDR_STROBE_FIRST   = 6'h30;
	localparam logic [5:0] ADDR_STROBE_LAST    = 6'h3D;
	localparam logic [5:0] ADDR_POWER_TABLE    = 6'h3E;
	localparam logic [5:0] ADDR_DATA_BUFFER    = 6'h3F;
	localparam int         STATUS_COUNT        = 14;

	// Header byte layout: bit 7 read, bit 6 burst, bits 5:0 address
	typedef struct packed {
		logic       read;
		logic       burst;
		logic [5:0] addr;
	} rspmp_hdr_type;

	// Field positions
	localparam int POLARITY_BIT = 6;
	localparam int DRIVE_BIT    = 7;
	localparam int TEMP_BIT     = 7;

	// Reset values
	localparam logic [7:0] RESET_PIN2_CFG       = 8'h29;
	localparam logic [7:0] RESET_PIN1_CFG       = 8'h2E;
	localparam logic [7:0] RESET_PIN0_CFG       = 8'h3F;
	localparam logic [7:0] RESET_FILL_THRESHOLD = 8'h07;

	// Signal select codes
	localparam logic [5:0] SEL_RX_THRESHOLD = 6'h00;
	localparam logic [5:0] SEL_TX_THRESHOLD = 6'h02;
	localparam logic [5:0] SEL_CHIP_READY   = 6'h29;
	localparam logic [5:0] SEL_HIGH_Z       = 6'h2E;
	localparam logic [5:0] SEL_CLOCK_DIV    = 6'h3F;

	// Buffer threshold arithmetic
	localparam logic [6:0] TX_THRESHOLD_BASE = 7'h3D;
	localparam logic [6:0] RX_THRESHOLD_BASE = 7'h04;

	// Divided oscillator clock
	localparam int CLOCK_DIVISOR = 192;
	localparam int CLOCK_HALF    = CLOCK_DIVISOR / 2;

endpackage

// >>> hdl/rspmp_top.sv
// Functional notes
// [R01] Write or single read at 0x30-0x3D issues a command strobe.
// [R02] Burst read at 0x30-0x3D returns a read-only status byte.
// [R03] Polarity bit 6 set makes the pin's selected signal active low.
// [R04] Pin 2 select bits 5:0 reset to 0x29, chip-ready low.
// [R05] Pin 1 select bits 5:0 reset to 0x2E, high impedance.
// [R06] Pin 0 select bits 5:0 reset to 0x3F, oscillator clock over 192.
// [R07] Host should reprogram pin 0 away from the clock at start-up.
// [R08] Pin 1 register bit 7 sets drive strength of all three pins.
// [R09] Host writes other bits zero when enabling the temperature sensor.
// [R10] Host writes zero into threshold register bits 7:4.
// [R11] Transmit threshold is 61 minus four times the setting.
// [R12] Receive threshold is four times the setting plus four.
// [R13] Pin and threshold registers hold their contents through sleep.
// [R14] Pin 2 register bit 7 reads zero and ignores writes.
// [R15] Header adds access type: single/burst write, single/burst read.
// [R16] 0x3E is power table; 0x3F is transmit buffer on write, receive on read.
// [R17] Threshold indications for both buffers, routable to output pins.
`timescale 1ns/1ps
`default_nettype none

module rspmp_top (
	// Clock and reset
	input  wire logic                   clock,
	input  wire logic                   rstn,
	// Serial port byte stream
	input  wire logic                   hdr_valid,
	input  wire rspmp_pkg::rspmp_hdr_type hdr,
	input  wire logic                   wr_valid,
	input  wire logic [7:0]             wr_data,
	input  wire logic                   rd_req,
	input  wire logic                   xfer_end,
	output logic                        rd_valid,
	output logic [7:0]                  rd_data,
	// Command strobes
	output logic                        strobe_valid,
	output logic [5:0]                  strobe_code,
	// Power table and data buffers
	output logic                        ptable_we,
	output logic                        ptable_re,
	input  wire logic [7:0]             ptable_rdata,
	output logic                        tx_push,
	output logic                        rx_pop,
	input  wire logic [7:0]             rx_rdata,
	// Device state
	input  wire logic [13:0][7:0]       status_bytes,
	input  wire logic [6:0]             tx_count,
	input  wire logic [6:0]             rx_count,
	input  wire logic                   chip_ready_low,
	input  wire logic [63:0]            sig_sources,
	// Output pins
	output logic [2:0]                  pin_out,
	output logic [2:0]                  pin_oe,
	output logic                        pin_drive_high,
	output logic                        temp_sensor_en,
	output logic                        tx_threshold,
	output logic                        rx_threshold
);

	typedef enum logic {ST_IDLE, ST_ACCESS} rspmp_state_type;

	rspmp_state_type state_q;
	logic [5:0]      addr_q;
	logic            read_q;
	logic            burst_q;
	logic [7:0]      pin_cfg_q [3];
	logic [7:0]      fill_thr_q;
	logic [7:0]      cfg_rdata;
	logic [7:0]      rd_data_d;
	logic [6:0]      clk_cnt_q;
	logic            clk_div_q;
	logic            tx_thr_q;
	logic            rx_thr_q;
	logic [6:0]      tx_level;
	logic [6:0]      rx_level;
	logic            wr_hit;
	logic            rd_hit;

	function automatic logic is_strobe_addr(input logic [5:0] a);
		is_strobe_addr = (a >= rspmp_pkg::ADDR_STROBE_FIRST) && (a <= rspmp_pkg::ADDR_STROBE_LAST);
	endfunction

	function automatic logic select_signal(input logic [5:0] code, input logic [63:0] src,
			input logic rx_t, input logic tx_t, input logic rdy, input logic ck);
		case (code)
			rspmp_pkg::SEL_RX_THRESHOLD: select_signal = rx_t;
			rspmp_pkg::SEL_TX_THRESHOLD: select_signal = tx_t;
			rspmp_pkg::SEL_CHIP_READY:   select_signal = rdy;
			rspmp_pkg::SEL_CLOCK_DIV:    select_signal = ck;
			default:                     select_signal = src[code];
		endcase
	endfunction

	assign wr_hit = (state_q == ST_ACCESS) && wr_valid && !read_q;
	assign rd_hit = (state_q == ST_ACCESS) && rd_req && read_q;

	// Transaction state: header opens it, end of select closes it
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			state_q <= ST_IDLE;
			addr_q  <= 6'h00;
			read_q  <= 1'b0;
			burst_q <= 1'b0;
		end else if (xfer_end) begin
			state_q <= ST_IDLE;
		end else if (hdr_valid) begin
			state_q <= ST_ACCESS;
			addr_q  <= hdr.addr;                                       // [R15]
			read_q  <= hdr.read;
			burst_q <= hdr.burst;
		end else if ((wr_hit || rd_hit) && burst_q && addr_q <= rspmp_pkg::ADDR_CONFIG_LAST) begin
			// Burst walks the configuration space; strobes and buffers stay put
			addr_q <= addr_q + 6'h01;                                  // [R15]
		end
	end

	// Strobes fire on the header itself, no data byte follows
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			strobe_valid <= 1'b0;
			strobe_code  <= 6'h00;
		end else begin
			// Released select wins over a header in the same cycle
			strobe_valid <= hdr_valid && !xfer_end && is_strobe_addr(hdr.addr)
				&& !(hdr.read && hdr.burst);                           // [R01]
			if (hdr_valid) begin
				strobe_code <= hdr.addr;
			end
		end
	end

	// Registers are cleared only by rstn, so sleep never disturbs them
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			pin_cfg_q[2] <= rspmp_pkg::RESET_PIN2_CFG;                 // [R04] [R13]
			pin_cfg_q[1] <= rspmp_pkg::RESET_PIN1_CFG;                 // [R05] [R08]
			pin_cfg_q[0] <= rspmp_pkg::RESET_PIN0_CFG;                 // [R06]
			fill_thr_q   <= rspmp_pkg::RESET_FILL_THRESHOLD;
		end else if (wr_hit) begin
			case (addr_q)
				rspmp_pkg::ADDR_PIN2_CFG:       pin_cfg_q[2] <= {1'b0, wr_data[6:0]}; // [R14]
				rspmp_pkg::ADDR_PIN1_CFG:       pin_cfg_q[1] <= wr_data;
				rspmp_pkg::ADDR_PIN0_CFG:       pin_cfg_q[0] <= wr_data;
				rspmp_pkg::ADDR_FILL_THRESHOLD: fill_thr_q   <= wr_data; // [R10]
				default: ;
			endcase
		end
	end

	assign ptable_we = wr_hit && (addr_q == rspmp_pkg::ADDR_POWER_TABLE);   // [R16]
	assign tx_push   = wr_hit && (addr_q == rspmp_pkg::ADDR_DATA_BUFFER);   // [R16]
	assign ptable_re = rd_hit && (addr_q == rspmp_pkg::ADDR_POWER_TABLE);   // [R16]
	assign rx_pop    = rd_hit && (addr_q == rspmp_pkg::ADDR_DATA_BUFFER);   // [R16]

	always_comb begin
		case (addr_q)
			rspmp_pkg::ADDR_PIN2_CFG:       cfg_rdata = pin_cfg_q[2];
			rspmp_pkg::ADDR_PIN1_CFG:       cfg_rdata = pin_cfg_q[1];
			rspmp_pkg::ADDR_PIN0_CFG:       cfg_rdata = pin_cfg_q[0];
			rspmp_pkg::ADDR_FILL_THRESHOLD: cfg_rdata = fill_thr_q;
			default:                        cfg_rdata = 8'h00;
		endcase
	end

	always_comb begin
		if (addr_q == rspmp_pkg::ADDR_POWER_TABLE) begin
			rd_data_d = ptable_rdata;
		end else if (addr_q == rspmp_pkg::ADDR_DATA_BUFFER) begin
			rd_data_d = rx_rdata;
		end else if (is_strobe_addr(addr_q)) begin
			// A single read here was a strobe; its data byte reads zero
			rd_data_d = burst_q ? status_bytes[4'(addr_q - rspmp_pkg::ADDR_STROBE_FIRST)] : 8'h00; // [R02]
		end else begin
			rd_data_d = cfg_rdata;
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			rd_valid <= 1'b0;
			rd_data  <= 8'h00;
		end else begin
			rd_valid <= rd_hit;
			if (rd_hit) begin
				rd_data <= rd_data_d;
			end
		end
	end

	// Oscillator clock over the divisor, as a square wave
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			clk_cnt_q <= 7'h00;
			clk_div_q <= 1'b0;
		end else if (clk_cnt_q == 7'(rspmp_pkg::CLOCK_HALF - 1)) begin
			clk_cnt_q <= 7'h00;
			clk_div_q <= ~clk_div_q;                                   // [R06]
		end else begin
			clk_cnt_q <= clk_cnt_q + 7'h01;
		end
	end

	// Levels are compared, so an indication holds while the count sits past it
	assign tx_level = rspmp_pkg::TX_THRESHOLD_BASE - {1'b0, fill_thr_q[3:0], 2'b00}; // [R11]
	assign rx_level = rspmp_pkg::RX_THRESHOLD_BASE + {1'b0, fill_thr_q[3:0], 2'b00}; // [R12]

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			tx_thr_q <= 1'b0;
			rx_thr_q <= 1'b0;
		end else begin
			tx_thr_q <= tx_count <= tx_level;                          // [R17] [R11]
			rx_thr_q <= rx_count >= rx_level;                          // [R17] [R12]
		end
	end

	assign tx_threshold = tx_thr_q;
	assign rx_threshold = rx_thr_q;

	generate
		for (genvar i = 0; i < 3; i++) begin : g_pin
			always_ff @(posedge clock or negedge rstn) begin
				if (!rstn) begin
					pin_out[i] <= 1'b0;
					pin_oe[i]  <= 1'b0;
				end else begin
					pin_out[i] <= select_signal(pin_cfg_q[i][5:0], sig_sources, rx_thr_q,
						tx_thr_q, chip_ready_low, clk_div_q)
						^ pin_cfg_q[i][rspmp_pkg::POLARITY_BIT];           // [R03] [R17]
					// Analog sensor output takes pin 0 away from the digital driver
					pin_oe[i]  <= (pin_cfg_q[i][5:0] != rspmp_pkg::SEL_HIGH_Z)
						&& !(i == 0 && pin_cfg_q[0][rspmp_pkg::TEMP_BIT]); // [R05] [R09]
				end
			end
		end
	endgenerate

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			pin_drive_high <= 1'b0;
			temp_sensor_en <= 1'b0;
		end else begin
			pin_drive_high <= pin_cfg_q[1][rspmp_pkg::DRIVE_BIT];      // [R08]
			temp_sensor_en <= pin_cfg_q[0][rspmp_pkg::TEMP_BIT];
		end
	end

endmodule // rspmp_top

`default_nettype wire

// >>> verification/rspmp_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module rspmp_monitor (
	// Clock and reset
	input wire logic			clock,
	input wire logic			rstn,
	// Byte stream
	input wire logic			hdr_valid,
	input wire rspmp_pkg::rspmp_hdr_type	hdr,
	input wire logic			wr_valid,
	input wire logic			rd_req,
	input wire logic			xfer_end,
	input wire logic			rd_valid,
	input wire logic [7:0]		rd_data,
	// Strobes and buffers
	input wire logic			strobe_valid,
	input wire logic [5:0]		strobe_code,
	input wire logic			ptable_we,
	input wire logic			ptable_re,
	input wire logic			tx_push,
	input wire logic			rx_pop
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);
	wire logic hit = hdr_valid && !xfer_end && hdr.addr >= rspmp_pkg::ADDR_STROBE_FIRST
		&& hdr.addr <= rspmp_pkg::ADDR_STROBE_LAST;
	wire logic stat = hdr.read && hdr.burst;
	chk_strobe_issue: assert property (hit && !stat |=> strobe_valid && strobe_code == $past(hdr.addr))
		else $error("strobe missing or wrong code");
	chk_strobe_cause: assert property (strobe_valid |-> $past(hit) && !$past(stat))
		else $error("strobe without strobe header");
	chk_status_quiet: assert property (hit && stat |=> !strobe_valid)
		else $error("status read fired a strobe");
	chk_end_wins: assert property (hdr_valid && xfer_end |=> !strobe_valid)
		else $error("header taken with chip select released");
	chk_read_delay: assert property (rd_valid |-> $past(rd_req))
		else $error("read byte without request");
	chk_read_hold: assert property (!rd_valid |-> $stable(rd_data))
		else $error("read data moved between reads");
	chk_buf_write: assert property (tx_push || ptable_we |-> wr_valid && !(tx_push && ptable_we))
		else $error("buffer write without data byte");
	chk_buf_read: assert property (rx_pop || ptable_re |-> rd_req && !(rx_pop && ptable_re))
		else $error("buffer read without request");
	cover property (strobe_valid);
	cover property (rd_valid);
	cover property (tx_push);
	cover property (rx_pop);
endmodule // rspmp_monitor
bind rspmp_top rspmp_monitor i_mon (
	.clock(clock), .rstn(rstn), .hdr_valid(hdr_valid), .hdr(hdr), .wr_valid(wr_valid),
	.rd_req(rd_req), .xfer_end(xfer_end), .rd_valid(rd_valid), .rd_data(rd_data),
	.strobe_valid(strobe_valid), .strobe_code(strobe_code), .ptable_we(ptable_we),
	.ptable_re(ptable_re), .tx_push(tx_push), .rx_pop(rx_pop));
`default_nettype wire

// >>> verification/rspmp_host.sv
`timescale 1ns/1ps
`default_nettype none
module rspmp_host (
	// Clock
	input wire logic			clock,
	// Byte stream toward the device
	output logic				hdr_valid,
	output var rspmp_pkg::rspmp_hdr_type	hdr,
	output logic				wr_valid,
	output logic [7:0]			wr_data,
	output logic				rd_req,
	output logic				xfer_end
);
	logic [8:0] exp_q[$];
	initial {hdr_valid, hdr, wr_valid, wr_data, rd_req, xfer_end} = '0;
	// Unqualified bytes show the inverse so stale values are never mistaken for data
	task automatic op(input logic [3:0] k, input logic [7:0] v);
		@(negedge clock);
		{xfer_end, rd_req, wr_valid, hdr_valid} = k;
		hdr = rspmp_pkg::rspmp_hdr_type'(k[0] ? v : ~v);
		wr_data = k[1] ? v : ~v;
	endtask
	task automatic head(input logic [7:0] h);
		if (h[5:0] >= 6'h30 && h[5:0] <= 6'h3D && h[7:6] != 2'b11)
			exp_q.push_back({3'b100, h[5:0]});
		op(4'h1, h);
	endtask
	task automatic rd(input logic [7:0] e);
		exp_q.push_back({1'b0, e});
		op(4'h4, 8'h00);
	endtask
endmodule // rspmp_host
`default_nettype wire

// >>> verification/radio_spi_map_and_pin_config_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin errors++; \
	$display("[ERR] %s exp %h got %h", n, e, g); end end
module radio_spi_map_and_pin_config_bench;
	logic				clock = 1'b0, rstn = 1'b0, chip_ready_low = 1'b0;
	logic [7:0]			ptable_rdata = 8'h00, rx_rdata = 8'h00, wr_data, rd_data;
	logic [13:0][7:0]		status_bytes = '0;
	logic [6:0]			tx_count = 7'h00, rx_count = 7'h00;
	logic [63:0]			sig_sources = '0;
	logic				hdr_valid, wr_valid, rd_req, xfer_end, rd_valid, strobe_valid;
	logic				ptable_we, ptable_re, tx_push, rx_pop, pin_drive_high;
	logic				temp_sensor_en, tx_threshold, rx_threshold;
	rspmp_pkg::rspmp_hdr_type	hdr;
	logic [5:0]			strobe_code, c;
	logic [2:0]			pin_out, pin_oe;
	logic [8:0]			e;
	logic [31:0]			r;
	int				errors = 0, check_count = 0, seed = 32'hfa6e;
	int				n_half = 0, n_push = 0, n_pwe = 0, n_pop = 0, n_pre = 0;
	rspmp_top i_dut (
		.clock(clock), .rstn(rstn), .hdr_valid(hdr_valid), .hdr(hdr),
		.wr_valid(wr_valid), .wr_data(wr_data), .rd_req(rd_req), .xfer_end(xfer_end),
		.rd_valid(rd_valid), .rd_data(rd_data), .strobe_valid(strobe_valid),
		.strobe_code(strobe_code), .ptable_we(ptable_we), .ptable_re(ptable_re),
		.ptable_rdata(ptable_rdata), .tx_push(tx_push), .rx_pop(rx_pop), .rx_rdata(rx_rdata),
		.status_bytes(status_bytes), .tx_count(tx_count), .rx_count(rx_count),
		.chip_ready_low(chip_ready_low), .sig_sources(sig_sources), .pin_out(pin_out),
		.pin_oe(pin_oe), .pin_drive_high(pin_drive_high), .temp_sensor_en(temp_sensor_en),
		.tx_threshold(tx_threshold), .rx_threshold(rx_threshold));
	rspmp_host i_host (
		.clock(clock), .hdr_valid(hdr_valid), .hdr(hdr), .wr_valid(wr_valid),
		.wr_data(wr_data), .rd_req(rd_req), .xfer_end(xfer_end));
	// Buffer pulses are combinational, so count them on the edge that takes them
	always @(posedge clock) begin
		if (tx_push === 1'b1) n_push++;
		if (ptable_we === 1'b1) n_pwe++;
		if (rx_pop === 1'b1) n_pop++;
		if (ptable_re === 1'b1) n_pre++;
	end
	always #20 clock = ~clock;
	function automatic logic [8:0] pop_exp();
		if (i_host.exp_q.size() == 0) return 9'h1FF;
		return i_host.exp_q.pop_front();
	endfunction
	always @(negedge clock) begin
		if (strobe_valid === 1'b1) begin
			e = pop_exp();
			`CHK("strobe", e, {3'b100, strobe_code})
		end
		if (rd_valid === 1'b1) begin
			e = pop_exp();
			`CHK("read", e, {1'b0, rd_data})
		end
	end
	task automatic stop_test();
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	initial begin
		#200000;
		errors++;
		stop_test();
	end
	initial begin
		repeat (8) @(negedge clock);
		rstn = 1'b1;
		foreach (status_bytes[k]) status_bytes[k] = 8'($random(seed));
		sig_sources = {$random(seed), $random(seed)};
		ptable_rdata = 8'($random(seed));
		rx_rdata = 8'($random(seed));
		chip_ready_low = 1'($random(seed));
		i_host.op(4'h0, 8'h00);
		`CHK("pin_oe", 3'b101, pin_oe)
		`CHK("pin2", chip_ready_low, pin_out[2])
		while (pin_out[0] !== 1'b1) @(negedge clock);
		while (pin_out[0] === 1'b1) begin
			@(negedge clock);
			n_half++;
		end
		`CHK("pin0_half", 192 / 2, n_half)
		i_host.op(4'h9, 8'h36);
		i_host.head(8'hC0);
		i_host.rd(8'h29);
		i_host.rd(8'h2E);
		i_host.rd(8'h3F);
		i_host.rd(8'h07);
		i_host.op(4'h8, 8'h00);
		r = $random(seed);
		c = 6'h03 + 6'(r[4:0]);
		i_host.head(8'h40);
		i_host.op(4'h2, {1'b1, r[6], c});
		i_host.op(4'h2, {r[7], 7'h2E});
		i_host.op(4'h2, 8'h80);
		i_host.op(4'h2, {4'h0, r[11:8]});
		i_host.op(4'h8, 8'h00);
		i_host.head(8'hC0);
		i_host.rd({1'b0, r[6], c});
		i_host.rd({r[7], 7'h2E});
		i_host.rd(8'h80);
		i_host.rd({4'h0, r[11:8]});
		i_host.op(4'h8, 8'h00);
		`CHK("pin2_out", sig_sources[c] ^ r[6], pin_out[2])
		`CHK("drive", r[7], pin_drive_high)
		`CHK("temp", 1'b1, temp_sensor_en)
		`CHK("pin0_oe", 1'b0, pin_oe[0])
		i_host.head(8'h02);
		i_host.op(4'h2, 8'h2E);
		i_host.head(8'h01);
		i_host.op(4'h2, 8'h02);
		i_host.head(8'h00);
		i_host.op(4'h2, 8'h00);
		i_host.op(4'h8, 8'h00);
		for (int t = 0; t < 16; t++) begin
			i_host.head(8'h03);
			i_host.op(4'h2, 8'(t));
			i_host.op(4'h8, 8'h00);
			tx_count = 7'(61 - 4 * t);
			rx_count = 7'(4 * t + 3);
			repeat (2) i_host.op(4'h0, 8'h00);
			`CHK("tx_thr", 1'b1, tx_threshold)
			`CHK("rx_thr", 1'b0, rx_threshold)
			`CHK("pin1_thr", 1'b1, pin_out[1])
			`CHK("pin2_thr", 1'b0, pin_out[2])
			tx_count++;
			rx_count++;
			repeat (2) i_host.op(4'h0, 8'h00);
			`CHK("tx_thr", 1'b0, tx_threshold)
			`CHK("rx_thr", 1'b1, rx_threshold)
			`CHK("pin2_thr", 1'b1, pin_out[2])
		end
		for (int a = 'h30; a <= 'h3D; a++) begin
			for (int m = 0; m < 4; m++) begin
				i_host.head(8'(a + 64 * m));
				if (m == 3) i_host.rd(status_bytes[a - 'h30]);
				i_host.op(4'h8, 8'h00);
			end
		end
		i_host.head(8'hBF);
		i_host.rd(rx_rdata);
		i_host.rd(rx_rdata);
		i_host.head(8'hFE);
		i_host.rd(ptable_rdata);
		i_host.head(8'h7F);
		i_host.op(4'h2, r[31:24]);
		i_host.head(8'h3E);
		i_host.op(4'h2, r[23:16]);
		i_host.op(4'h8, 8'h00);
		repeat (3) i_host.op(4'h0, 8'h00);
		`CHK("tx_push", 1, n_push)
		`CHK("ptable_we", 1, n_pwe)
		`CHK("rx_pop", 2, n_pop)
		`CHK("ptable_re", 1, n_pre)
		stop_test();
	end
endmodule // radio_spi_map_and_pin_config_bench
`default_nettype wire
